// file: design/sdc_host.sv
`timescale 1ns/100ps
module sdc_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Slave port
  input wire logic [sdc_pkg::HADDR_W-1:0] host_addr,
  input wire logic host_read,
  input wire logic host_write,
  input wire logic [sdc_pkg::DQ_W-1:0] host_wdata,
  input wire logic [sdc_pkg::BE_W-1:0] host_be,
  output logic host_waitreq,
  output logic [sdc_pkg::DQ_W-1:0] host_rdata,
  output logic host_rvalid,
  // Toward the link engine
  sdc_xfer_if.host_mp xf
);
  import sdc_pkg::*;
  logic busy_reg;
  logic req_tgl_reg;
  logic ack_seen_reg;
  logic we_reg;
  logic [HADDR_W-1:0] addr_reg;
  logic [DQ_W-1:0] wdata_reg;
  logic [BE_W-1:0] be_reg;
  logic [DQ_W-1:0] rdata_reg;
  logic rvalid_reg;
  logic accept;
  logic ack_ev;

  // Stall until initialised and until the previous transfer is answered
  assign host_waitreq = !xf.ready_sync || busy_reg;
  assign accept = (host_read || host_write) && !host_waitreq;
  assign ack_ev = xf.ack_sync ^ ack_seen_reg;
  assign xf.req_tgl = req_tgl_reg;
  assign xf.addr = addr_reg;
  assign xf.wdata = wdata_reg;
  assign xf.be = be_reg;
  assign xf.we = we_reg;
  assign host_rdata = rdata_reg;
  assign host_rvalid = rvalid_reg;

  // Request capture and toggle toward the link domain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      be_reg <= '0;
    end else if (accept) begin
      busy_reg <= 1'b1;
      req_tgl_reg <= !req_tgl_reg;
      we_reg <= host_write;
      addr_reg <= host_addr;
      wdata_reg <= host_wdata;
      be_reg <= host_be;
    end else if (ack_ev) begin
      busy_reg <= 1'b0;
    end
  end

  // Read answer, one pulse per finished read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_seen_reg <= 1'b0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      ack_seen_reg <= xf.ack_sync;
      rvalid_reg <= ack_ev && !we_reg;
      if (ack_ev && !we_reg) begin
        rdata_reg <= xf.rdata;
      end
    end
  end

  wait_init_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !xf.ready_sync |-> host_waitreq) else $error("port open before init");
  busy_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept |=> host_waitreq [*3]) else $error("no wait after accept");
  read_latency_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && !host_write |-> ##[4:1000] host_rvalid) else $error("read never answered");
  read_cov: cover property (@(posedge core_clk) disable iff (!rst_n) host_rvalid);
  write_cov: cover property (@(posedge core_clk) disable iff (!rst_n) accept && host_write);
endmodule : sdc_host

// file: design/sdc_pkg.sv
package sdc_pkg;
  // Build-time geometry; the data width may be 8, 16, 32 or 64
  localparam int DQ_W = 32;
  localparam int BE_W = DQ_W / 8;
  localparam int COL_W = 8;
  localparam int ROW_W = 12;
  localparam int BANK_W = 2;
  localparam int NUM_CS = 2;
  localparam int CS_W = 1;
  localparam int HADDR_W = CS_W + BANK_W + ROW_W + COL_W;
  // Pins shared with a tri-state bridge
  localparam bit SHARE_BRIDGE = 1'b1;

  // Timing at the controller clock rate
  localparam int CLK_PERIOD_NS = 20;
  localparam int CNT_W = 16;
  localparam int T_POWERUP_NS = 100000;
  localparam int POWERUP_CYC = (T_POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RP_NS = 20;
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int T_RCD_NS = 20;
  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int T_RFC_NS = 70;
  localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'((T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int T_WR_NS = 15;
  localparam logic [CNT_W-1:0] WR_CYC = CNT_W'((T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int T_REFI_NS = 15625;
  localparam logic [CNT_W-1:0] REFI_CYC = CNT_W'(T_REFI_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MRD_CYC = 16'h0002;
  localparam int CAS_LAT = 2;
  localparam logic [CNT_W-1:0] RD_CAPTURE_CYC = CNT_W'(CAS_LAT + 3);
  localparam logic [3:0] INIT_REFRESHES = 4'h8;
  localparam logic [3:0] KEEP_OPEN_CYC = 4'h8;

  // Pin values: mode word is burst 1, sequential, latency 2
  localparam logic [ROW_W-1:0] MODE_VALUE = 12'h020;
  localparam logic [ROW_W-1:0] PALL_ADDR = 12'h400;

  // Commands as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  typedef enum logic [9:0] {
    ST_POWERUP = 10'h001,
    ST_PALL = 10'h002,
    ST_AREF = 10'h004,
    ST_LMR = 10'h008,
    ST_IDLE = 10'h010,
    ST_ACT = 10'h020,
    ST_RW = 10'h040,
    ST_RDWAIT = 10'h080,
    ST_PRE = 10'h100,
    ST_DELAY = 10'h200
  } sdc_state_t;
endpackage : sdc_pkg

// file: design/sdc_sync.sv
`timescale 1ns/100ps
module sdc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // Two flops; the first feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sdc_sync

// file: design/sdc_top.sv
`timescale 1ns/100ps
// Functional notes
// - The slave port maps the whole memory as one flat linear space, with no registers.
// - A pending read or write is stalled by wait until it can be completed.
// - Reads are accepted with variable latency and answered by a data-valid strobe.
// - Host traffic is suspended periodically to refresh the memory.
// - All command sequences, delays, refresh and row handling are generated here.
// - Data width, memory size and chip-select count are build-time choices.
// - Every option is fixed at build time and nothing changes while running.
// - Clock enable is held high, with no suspend or power-down modes.
// - Address, data and mask pins may be shared through a tri-state bridge.
// - The bridge stays owned while accesses keep hitting the same row and bank.
// - The open row is closed when back-to-back traffic stops or a refresh is due.
module sdc_top #(
  parameter int POWERUP_CYCLES = sdc_pkg::POWERUP_CYC
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic sdram_clk,
  input wire logic rst_n,
  // Slave port
  input wire logic [sdc_pkg::HADDR_W-1:0] host_addr,
  input wire logic host_read,
  input wire logic host_write,
  input wire logic [sdc_pkg::DQ_W-1:0] host_wdata,
  input wire logic [sdc_pkg::BE_W-1:0] host_be,
  output logic host_waitreq,
  output logic [sdc_pkg::DQ_W-1:0] host_rdata,
  output logic host_rvalid,
  // Memory pins
  output logic sdram_cke,
  output logic [sdc_pkg::NUM_CS-1:0] sdram_cs_n,
  output logic sdram_ras_n,
  output logic sdram_cas_n,
  output logic sdram_we_n,
  output logic [sdc_pkg::BANK_W-1:0] sdram_ba,
  output logic [sdc_pkg::ROW_W-1:0] sdram_addr,
  output logic sdram_addr_oe,
  output logic [sdc_pkg::BE_W-1:0] sdram_dqm,
  input wire logic [sdc_pkg::DQ_W-1:0] sdram_dq_in,
  output logic [sdc_pkg::DQ_W-1:0] sdram_dq_out,
  output logic sdram_dq_oe,
  // Tri-state bridge arbitration
  output logic bridge_req,
  input wire logic bridge_grant
);
  import sdc_pkg::*;
  sdc_xfer_if xf ();

  sdc_state_t st_reg;
  sdc_state_t nxt_reg;
  logic [CNT_W-1:0] dly_reg;
  logic [3:0] refs_left_reg;
  logic ready_reg;
  logic [1:0] lsync_q;
  logic [1:0] csync_q;
  logic [DQ_W-1:0] dq_q;
  logic req_sync;
  logic req_seen_reg;
  logic pend_reg;
  logic ack_tgl_reg;
  logic [DQ_W-1:0] rdata_reg;
  logic own;
  logic hit;
  logic row_open_reg;
  logic [CS_W-1:0] open_cs_reg;
  logic [BANK_W-1:0] open_bank_reg;
  logic [ROW_W-1:0] open_row_reg;
  logic [3:0] keep_cnt_reg;
  logic [CNT_W-1:0] ref_cnt_reg;
  logic ref_due_reg;
  logic bridge_req_reg;
  logic addr_oe_reg;
  logic [2:0] cmd_reg;
  logic [NUM_CS-1:0] cs_n_reg;
  logic [BANK_W-1:0] ba_reg;
  logic [ROW_W-1:0] a_reg;
  logic [BE_W-1:0] dqm_reg;
  logic [DQ_W-1:0] dq_o_reg;
  logic dq_oe_reg;

  // Flat host word address split as {chip, bank, row, column}
  function automatic logic [COL_W-1:0] f_col(input logic [HADDR_W-1:0] a);
    return a[COL_W-1:0];
  endfunction : f_col

  function automatic logic [ROW_W-1:0] f_row(input logic [HADDR_W-1:0] a);
    return a[COL_W +: ROW_W];
  endfunction : f_row

  function automatic logic [BANK_W-1:0] f_bank(input logic [HADDR_W-1:0] a);
    return a[COL_W + ROW_W +: BANK_W];
  endfunction : f_bank

  function automatic logic [CS_W-1:0] f_cs(input logic [HADDR_W-1:0] a);
    return a[HADDR_W-1 -: CS_W];
  endfunction : f_cs

  function automatic logic [NUM_CS-1:0] f_csn(input logic [CS_W-1:0] c);
    logic [NUM_CS-1:0] one;
    one = NUM_CS'(1);
    return ~(one << c);
  endfunction : f_csn

  // Host side in the core domain
  sdc_host u_host (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .host_addr(host_addr),
    .host_read(host_read),
    .host_write(host_write),
    .host_wdata(host_wdata),
    .host_be(host_be),
    .host_waitreq(host_waitreq),
    .host_rdata(host_rdata),
    .host_rvalid(host_rvalid),
    .xf(xf.host_mp)
  );

  // Crossings: request toggle and grant into link, ack and ready into core
  sdc_sync #(.W(2)) u_lsync (
    .clk(sdram_clk),
    .rst_n(rst_n),
    .d({xf.req_tgl, bridge_grant}),
    .q(lsync_q)
  );

  sdc_sync #(.W(2)) u_csync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d({ack_tgl_reg, ready_reg}),
    .q(csync_q)
  );

  // Read data pins pass two flops before capture
  sdc_sync #(.W(DQ_W)) u_dqsync (
    .clk(sdram_clk),
    .rst_n(rst_n),
    .d(sdram_dq_in),
    .q(dq_q)
  );

  assign req_sync = lsync_q[1];
  assign own = lsync_q[0] || !SHARE_BRIDGE;
  assign xf.ack_sync = csync_q[1];
  assign xf.ready_sync = csync_q[0];
  assign xf.rdata = rdata_reg;
  assign hit = row_open_reg && f_cs(xf.addr) == open_cs_reg
    && f_bank(xf.addr) == open_bank_reg && f_row(xf.addr) == open_row_reg;

  // Command sequencer
  always_ff @(posedge sdram_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_POWERUP;
      nxt_reg <= ST_IDLE;
      dly_reg <= CNT_W'(POWERUP_CYCLES);
      refs_left_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      case (st_reg)
        ST_POWERUP: begin
          if (dly_reg > CNT_W'(1)) begin
            dly_reg <= dly_reg - CNT_W'(1);
          end else if (own) begin
            st_reg <= ST_PALL;
          end
        end
        ST_PALL: begin
          refs_left_reg <= INIT_REFRESHES;
          nxt_reg <= ST_AREF;
          dly_reg <= RP_CYC;
          st_reg <= ST_DELAY;
        end
        ST_AREF: begin
          refs_left_reg <= refs_left_reg - 4'h1;
          if (refs_left_reg > 4'h1) begin
            nxt_reg <= ST_AREF;
          end else if (ready_reg) begin
            nxt_reg <= ST_IDLE;
          end else begin
            nxt_reg <= ST_LMR;
          end
          dly_reg <= RFC_CYC;
          st_reg <= ST_DELAY;
        end
        ST_LMR: begin
          ready_reg <= 1'b1;
          nxt_reg <= ST_IDLE;
          dly_reg <= MRD_CYC;
          st_reg <= ST_DELAY;
        end
        ST_IDLE: begin
          if (own) begin
            if (ref_due_reg) begin
              if (row_open_reg) begin
                st_reg <= ST_PRE;
              end else begin
                refs_left_reg <= 4'h1;
                st_reg <= ST_AREF;
              end
            end else if (pend_reg) begin
              if (!row_open_reg) begin
                st_reg <= ST_ACT;
              end else if (hit) begin
                st_reg <= ST_RW;
              end else begin
                st_reg <= ST_PRE;
              end
            end else if (row_open_reg && keep_cnt_reg == 4'h0) begin
              st_reg <= ST_PRE;
            end
          end
        end
        ST_ACT: begin
          nxt_reg <= ST_RW;
          dly_reg <= RCD_CYC;
          st_reg <= ST_DELAY;
        end
        ST_PRE: begin
          nxt_reg <= ST_IDLE;
          dly_reg <= RP_CYC;
          st_reg <= ST_DELAY;
        end
        ST_RW: begin
          if (xf.we) begin
            nxt_reg <= ST_IDLE;
            dly_reg <= WR_CYC;
            st_reg <= ST_DELAY;
          end else begin
            dly_reg <= RD_CAPTURE_CYC;
            st_reg <= ST_RDWAIT;
          end
        end
        ST_RDWAIT: begin
          dly_reg <= dly_reg - CNT_W'(1);
          if (dly_reg == CNT_W'(1)) begin
            st_reg <= ST_IDLE;
          end
        end
        ST_DELAY: begin
          dly_reg <= dly_reg - CNT_W'(1);
          if (dly_reg <= CNT_W'(1)) begin
            st_reg <= nxt_reg;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Pending request and answer toggle; a new request wins over the clear
  always_ff @(posedge sdram_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen_reg <= 1'b0;
      pend_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      req_seen_reg <= req_sync;
      if (req_sync ^ req_seen_reg) begin
        pend_reg <= 1'b1;
      end else if ((st_reg == ST_RW && xf.we)
          || (st_reg == ST_RDWAIT && dly_reg == CNT_W'(1))) begin
        pend_reg <= 1'b0;
      end
      if (st_reg == ST_RW && xf.we) begin
        ack_tgl_reg <= !ack_tgl_reg;
      end
      if (st_reg == ST_RDWAIT && dly_reg == CNT_W'(1)) begin
        rdata_reg <= dq_q;
        ack_tgl_reg <= !ack_tgl_reg;
      end
    end
  end

  // Open row tracking and the back-to-back window
  always_ff @(posedge sdram_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_open_reg <= 1'b0;
      open_cs_reg <= '0;
      open_bank_reg <= '0;
      open_row_reg <= '0;
      keep_cnt_reg <= '0;
    end else begin
      if (st_reg == ST_ACT) begin
        row_open_reg <= 1'b1;
        open_cs_reg <= f_cs(xf.addr);
        open_bank_reg <= f_bank(xf.addr);
        open_row_reg <= f_row(xf.addr);
      end else if (st_reg == ST_PRE || st_reg == ST_PALL) begin
        row_open_reg <= 1'b0;
      end
      if (st_reg == ST_RW) begin
        keep_cnt_reg <= KEEP_OPEN_CYC;
      end else if (st_reg == ST_IDLE && !pend_reg && keep_cnt_reg != 4'h0) begin
        keep_cnt_reg <= keep_cnt_reg - 4'h1;
      end
    end
  end

  // Refresh interval timer; expiry sets due, set wins over the clear
  always_ff @(posedge sdram_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_reg <= REFI_CYC;
      ref_due_reg <= 1'b0;
    end else if (ready_reg) begin
      if (ref_cnt_reg <= CNT_W'(1)) begin
        ref_cnt_reg <= REFI_CYC;
        ref_due_reg <= 1'b1;
      end else begin
        ref_cnt_reg <= ref_cnt_reg - CNT_W'(1);
        if (st_reg == ST_AREF) begin
          ref_due_reg <= 1'b0;
        end
      end
    end
  end

  // Bridge ownership held through init, pending work and open rows
  always_ff @(posedge sdram_clk or negedge rst_n) begin
    if (!rst_n) begin
      bridge_req_reg <= 1'b0;
      addr_oe_reg <= 1'b0;
    end else begin
      bridge_req_reg <= st_reg != ST_IDLE || pend_reg || row_open_reg || ref_due_reg;
      addr_oe_reg <= own && bridge_req_reg;
    end
  end

  // Command, address and data pins, one command per state visit
  always_ff @(posedge sdram_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= CMD_NOP;
      cs_n_reg <= '1;
      ba_reg <= '0;
      a_reg <= '0;
      dqm_reg <= '1;
      dq_o_reg <= '0;
      dq_oe_reg <= 1'b0;
    end else begin
      cmd_reg <= CMD_NOP;
      cs_n_reg <= '1;
      dq_oe_reg <= 1'b0;
      dqm_reg <= '0;
      case (st_reg)
        ST_PALL: begin
          cmd_reg <= CMD_PRE;
          cs_n_reg <= '0;
          a_reg <= PALL_ADDR;
        end
        ST_AREF: begin
          cmd_reg <= CMD_REF;
          cs_n_reg <= '0;
        end
        ST_LMR: begin
          cmd_reg <= CMD_LMR;
          cs_n_reg <= '0;
          ba_reg <= '0;
          a_reg <= MODE_VALUE;
        end
        ST_ACT: begin
          cmd_reg <= CMD_ACT;
          cs_n_reg <= f_csn(f_cs(xf.addr));
          ba_reg <= f_bank(xf.addr);
          a_reg <= f_row(xf.addr);
        end
        ST_PRE: begin
          cmd_reg <= CMD_PRE;
          cs_n_reg <= f_csn(open_cs_reg);
          ba_reg <= open_bank_reg;
          a_reg <= '0;
        end
        ST_RW: begin
          cmd_reg <= xf.we ? CMD_WR : CMD_RD;
          cs_n_reg <= f_csn(open_cs_reg);
          ba_reg <= open_bank_reg;
          a_reg <= ROW_W'(f_col(xf.addr));
          dqm_reg <= xf.we ? ~xf.be : '0;
          dq_o_reg <= xf.wdata;
          dq_oe_reg <= xf.we;
        end
        default: begin
          cmd_reg <= CMD_NOP;
        end
      endcase
    end
  end

  assign sdram_cke = 1'b1;
  assign {sdram_ras_n, sdram_cas_n, sdram_we_n} = cmd_reg;
  assign sdram_cs_n = cs_n_reg;
  assign sdram_ba = ba_reg;
  assign sdram_addr = a_reg;
  assign sdram_addr_oe = addr_oe_reg;
  assign sdram_dqm = dqm_reg;
  assign sdram_dq_out = dq_o_reg;
  assign sdram_dq_oe = dq_oe_reg;
  assign bridge_req = bridge_req_reg;

  cke_high_a: assert property (@(posedge sdram_clk) disable iff (!rst_n)
    sdram_cke) else $error("clock enable dropped");
  ref_closed_a: assert property (@(posedge sdram_clk) disable iff (!rst_n)
    cmd_reg == CMD_REF |-> !row_open_reg) else $error("refresh with open row");
  rw_hit_a: assert property (@(posedge sdram_clk) disable iff (!rst_n)
    st_reg == ST_RW |-> hit) else $error("access outside open row");
  ref_issue_a: assert property (@(posedge sdram_clk) disable iff (!rst_n)
    st_reg == ST_IDLE && own && ref_due_reg && !row_open_reg |-> ##2 cmd_reg == CMD_REF)
    else $error("due refresh not issued");
  break_close_a: assert property (@(posedge sdram_clk) disable iff (!rst_n)
    st_reg == ST_IDLE && own && !pend_reg && row_open_reg && keep_cnt_reg == 4'h0
    |-> ##2 cmd_reg == CMD_PRE) else $error("row left open after break");
  bus_hold_a: assert property (@(posedge sdram_clk) disable iff (!rst_n)
    row_open_reg && $past(row_open_reg) |-> bridge_req_reg) else $error("bridge let go");
  init_order_a: assert property (@(posedge sdram_clk) disable iff (!rst_n)
    st_reg == ST_LMR |-> refs_left_reg == 4'h0 && !ready_reg) else $error("bad init order");
  dq_owned_a: assert property (@(posedge sdram_clk) disable iff (!rst_n)
    sdram_dq_oe |-> sdram_addr_oe) else $error("data driven without bridge");
  refresh_cov: cover property (@(posedge sdram_clk) disable iff (!rst_n)
    cmd_reg == CMD_REF && ready_reg);
  row_hit_cov: cover property (@(posedge sdram_clk) disable iff (!rst_n)
    st_reg == ST_IDLE && pend_reg && hit && own);
  miss_cov: cover property (@(posedge sdram_clk) disable iff (!rst_n)
    st_reg == ST_IDLE && pend_reg && row_open_reg && !hit && own && !ref_due_reg);
endmodule : sdc_top

// file: design/sdc_xfer_if.sv
`timescale 1ns/100ps
interface sdc_xfer_if;
  import sdc_pkg::*;
  // Request words, held stable while the toggle crosses
  logic req_tgl;
  logic [HADDR_W-1:0] addr;
  logic [DQ_W-1:0] wdata;
  logic [BE_W-1:0] be;
  logic we;
  // Answers; ack and ready already synchronised into the core domain, read data held stable
  logic ack_sync;
  logic ready_sync;
  logic [DQ_W-1:0] rdata;
  modport host_mp (output req_tgl, addr, wdata, be, we, input ack_sync, ready_sync, rdata);
  modport ctrl_mp (input req_tgl, addr, wdata, be, we, output ack_sync, ready_sync, rdata);
endinterface : sdc_xfer_if

// file: testbench/sdc_mem_model.sv
`timescale 1ns/100ps
module sdc_mem_model
  import sdc_pkg::*;
(
  // Link clock and reset
  input wire logic sdram_clk,
  input wire logic rst_n,
  // Command pins
  input wire logic cke,
  input wire logic [NUM_CS-1:0] cs_n,
  input wire logic [2:0] cmd,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ROW_W-1:0] addr,
  input wire logic [BE_W-1:0] dqm,
  // Data pins
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [DQ_W-1:0] dq_in,
  // Bridge arbitration
  input wire logic bridge_req,
  output logic bridge_grant,
  // Observed counts
  output int prot_err,
  output int ref_cnt
);
  logic [DQ_W-1:0] mem [logic [HADDR_W-1:0]];
  logic [ROW_W-1:0] row_reg [8];
  logic [7:0] open_reg;
  logic [DQ_W-1:0] rd_data;
  logic [3:0] rd_pipe;
  logic init_done, pall_seen;
  logic [2:0] idx;
  logic [HADDR_W-1:0] key;

  // Command decode, open-row and power-up order bookkeeping
  always @(posedge sdram_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_reg = '0;
      rd_pipe = '0;
      init_done = 0;
      pall_seen = 0;
      bridge_grant <= 0;
    end else begin
      bridge_grant <= bridge_req;
      if (cke !== 1'b1) prot_err++;
      idx = {~cs_n[0], ba};
      key = {idx, row_reg[idx], addr[7:0]};
      rd_pipe = {rd_pipe[2:0], 1'b0};
      // Data drive only in the write command cycle
      if (dq_oe === 1'b1 && (cs_n == 2'h3 || cmd != CMD_WR)) prot_err++;
      if (cs_n != 2'h3) case (cmd)
        CMD_ACT: begin
          if (open_reg[idx] || !init_done) prot_err++;
          open_reg[idx] = 1;
          row_reg[idx] = addr;
        end
        CMD_PRE: begin
          if (addr[10]) open_reg = '0;
          else open_reg[idx] = 0;
          pall_seen |= addr[10];
        end
        CMD_REF: begin
          if (open_reg != 0 || !pall_seen) prot_err++;
          ref_cnt++;
        end
        CMD_LMR: begin
          init_done = pall_seen && ref_cnt >= 2;
          ref_cnt = 0;
        end
        CMD_WR: begin
          if (!open_reg[idx] || !init_done || dq_oe !== 1'b1) prot_err++;
          if (!mem.exists(key)) mem[key] = '0;
          for (int b = 0; b < BE_W; b++) if (!dqm[b]) mem[key][8*b+:8] = dq_out[8*b+:8];
        end
        CMD_RD: begin
          if (!open_reg[idx] || !init_done) prot_err++;
          rd_data = mem.exists(key) ? mem[key] : '0;
          rd_pipe[0] = 1;
        end
        default: ;
      endcase
    end
  end

  // Data out two cycles after the read, inverted garbage otherwise
  always @(posedge sdram_clk) begin
    #1;
    dq_in = (rd_pipe[1] | rd_pipe[2]) ? rd_data : ~rd_data;
  end
endmodule : sdc_mem_model

// file: testbench/sdram_controller_host_port_test.sv
`timescale 1ns/100ps
module sdram_controller_host_port_test;
  import sdc_pkg::*;
  logic core_clk = 0, sdram_clk = 0, rst_n = 0, host_read = 0, host_write = 0, grant;
  logic host_waitreq, host_rvalid, cke, ras_n, cas_n, we_n, addr_oe, dq_oe, breq;
  logic [HADDR_W-1:0] host_addr = '0;
  logic [DQ_W-1:0] host_wdata = '0, host_rdata, dq_in, dq_out;
  logic [BE_W-1:0] host_be = '0, dqm;
  logic [NUM_CS-1:0] cs_n;
  logic [BANK_W-1:0] ba;
  logic [ROW_W-1:0] sd_addr;
  int err_total = 0, samples_checked = 0, ref_cnt, prot_err, r;

  sdc_top #(.POWERUP_CYCLES(20)) sdc_top_i (.core_clk(core_clk), .sdram_clk(sdram_clk),
    .rst_n(rst_n), .host_addr(host_addr), .host_read(host_read), .host_write(host_write),
    .host_wdata(host_wdata), .host_be(host_be), .host_waitreq(host_waitreq),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .sdram_cke(cke), .sdram_cs_n(cs_n),
    .sdram_ras_n(ras_n), .sdram_cas_n(cas_n), .sdram_we_n(we_n), .sdram_ba(ba),
    .sdram_addr(sd_addr), .sdram_addr_oe(addr_oe), .sdram_dqm(dqm), .sdram_dq_in(dq_in),
    .sdram_dq_out(dq_out), .sdram_dq_oe(dq_oe), .bridge_req(breq), .bridge_grant(grant));
  sdc_mem_model sdc_mem_model_i (.sdram_clk(sdram_clk), .rst_n(rst_n), .cke(cke),
    .cs_n(cs_n), .cmd({ras_n, cas_n, we_n}), .ba(ba), .addr(sd_addr), .dqm(dqm),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .bridge_req(breq), .bridge_grant(grant),
    .prot_err(prot_err), .ref_cnt(ref_cnt));

  // Clocks, link clock unrelated in phase
  initial forever #10 core_clk = ~core_clk;
  initial begin
    #3;
    forever #7.5 sdram_clk = ~sdram_clk;
  end

  task check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Bounded wait for a signal level at falling edges
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v) begin
      @(negedge core_clk);
      n++;
      if (n > 1000) begin
        err_total++;
        tally_and_finish;
      end
    end
  endtask : wait_for

  // One transfer, held until a rising edge sees wait low
  task xfer(logic wr, logic [HADDR_W-1:0] a, logic [31:0] d, logic [3:0] be);
    host_addr = a;
    host_wdata = d;
    host_be = be;
    host_write = wr;
    host_read = !wr;
    wait_for(host_waitreq, 1'b0);
    @(negedge core_clk);
    host_write = 0;
    host_read = 0;
    // Let an edge pass before any next request
    @(negedge core_clk);
  endtask : xfer

  task rd(logic [HADDR_W-1:0] a, logic [31:0] exp);
    xfer(0, a, '0, '0);
    wait_for(host_rvalid, 1'b1);
    check("rdata", host_rdata, exp);
  endtask : rd

  task sc_reset;
    check("wait_in_reset", host_waitreq, 1);
    check("rvalid_in_reset", host_rvalid, 0);
    check("oe_in_reset", {29'h0, breq, addr_oe, dq_oe}, 0);
    check("cke", cke, 1);
    rst_n = 1;
    repeat (10) @(negedge core_clk);
    check("wait_powerup", host_waitreq, 1);
  endtask : sc_reset

  // Back-to-back hits in one row, then a bank, row and chip miss
  task sc_rows;
    for (int i = 0; i < 4; i++) xfer(1, 23'h000100 + i, 32'h11110000 + i, 4'hf);
    for (int i = 0; i < 4; i++) rd(23'h000100 + i, 32'h11110000 + i);
    xfer(1, 23'h100100, 32'ha5a5a5a5, 4'hf);
    xfer(1, 23'h000200, 32'h5a5a5a5a, 4'hf);
    xfer(1, 23'h400100, 32'hc3c3c3c3, 4'hf);
    rd(23'h100100, 32'ha5a5a5a5);
    rd(23'h000200, 32'h5a5a5a5a);
    rd(23'h400100, 32'hc3c3c3c3);
    rd(23'h000101, 32'h11110001);
  endtask : sc_rows

  task sc_mask;
    xfer(1, 23'h7fffff, 32'hffffffff, 4'hf);
    xfer(1, 23'h7fffff, 32'h00000000, 4'h5);
    rd(23'h7fffff, 32'hff00ff00);
  endtask : sc_mask

  task sc_refresh;
    r = ref_cnt;
    repeat (700) @(negedge core_clk);
    check("refresh_seen", 32'(ref_cnt > r), 1);
    rd(23'h000103, 32'h11110003);
    check("protocol", 32'(prot_err), 0);
  endtask : sc_refresh

  initial begin
    repeat (8) @(negedge core_clk);
    sc_reset;
    sc_rows;
    sc_mask;
    sc_refresh;
    tally_and_finish;
  end
endmodule : sdram_controller_host_port_test
